// file: dv/cbc_engine_model.sv
// Behavioural CAN engine that answers transmit starts
`timescale 1ns/1ps
module cbc_engine_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic tx_start,
   input wire logic tx_abort,
   input wire logic [1:0] mode,
   input wire logic [3:0] delay,
   output logic tx_ok,
   output logic tx_aborted,
   output logic tx_arb_lost,
   output logic tx_bus_err
);
   logic busy_reg;
   logic [3:0] cnt_reg;

   // Mode 0 sent, 1 lost, 2 bus error, 3 hold until abort
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         busy_reg <= 1'b0;
         cnt_reg <= 4'h0;
         tx_ok <= 1'b0;
         tx_aborted <= 1'b0;
         tx_arb_lost <= 1'b0;
         tx_bus_err <= 1'b0;
      end else begin
         tx_ok <= 1'b0;
         tx_aborted <= 1'b0;
         tx_arb_lost <= 1'b0;
         tx_bus_err <= 1'b0;
         if (!busy_reg) begin
            busy_reg <= tx_start;
            cnt_reg <= delay;
         end else if (tx_abort) begin
            tx_aborted <= 1'b1;
            busy_reg <= 1'b0;
         end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
         end else if (mode != 2'h3) begin
            tx_ok <= (mode == 2'h0);
            tx_arb_lost <= (mode == 2'h1);
            tx_bus_err <= (mode == 2'h2);
            busy_reg <= 1'b0;
         end
      end
   end
endmodule

// file: dv/tb_can_tx_rx_buffer_control.sv
// Self-checking bench for the CAN buffer pair control block
`timescale 1ns/1ps
module tb_can_tx_rx_buffer_control;
   // ****************************************
   // Signals
   // ****************************************
   logic clk_sys, rst, hsel, hwrite, hready, hreadyout, hresp, rd_chk;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, rx_remote, tx_prio, buf_is_tx, mode;
   logic [2:0] hsize;
   logic [3:0] delay;
   logic tx_ok, tx_aborted, tx_arb_lost, tx_bus_err;
   logic tx_start, tx_buf, tx_abort, irq;
   int err_count = 0;
   int checked = 0;
   int n_start = 0;
   int n_out = 0;
   logic [31:0] exp_rd[$];
   logic [2:0] exp_tx[$];

   assign hready = hreadyout;

   cbc_buffer_pair_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .tx_ok(tx_ok),
      .tx_aborted(tx_aborted), .tx_arb_lost(tx_arb_lost),
      .tx_bus_err(tx_bus_err), .rx_remote(rx_remote),
      .tx_start(tx_start), .tx_buf(tx_buf), .tx_prio(tx_prio),
      .tx_abort(tx_abort), .buf_is_tx(buf_is_tx), .irq(irq));

   cbc_engine_model u_engine (.clk_sys(clk_sys), .rst(rst),
      .tx_start(tx_start), .tx_abort(tx_abort), .mode(mode),
      .delay(delay), .tx_ok(tx_ok), .tx_aborted(tx_aborted),
      .tx_arb_lost(tx_arb_lost), .tx_bus_err(tx_bus_err));

   // Clock generator
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic complete_run();
      $display("Counts: checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic time_out();
      err_count++;
      $display("ERROR t=%0t wait limit ran out", $time);
      complete_run();
   endtask

   task automatic wait_rdy();
      int i;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_sys);
         if (hready === 1'b1) return;
      end
      time_out();
   endtask

   // Waits for a count of starts or of engine outcomes
   task automatic wait_ev(input bit on_start, input int target);
      int i;
      for (i = 0; i < 300; i++) begin
         @(posedge clk_sys);
         if ((on_start ? n_start : n_out) >= target) return;
      end
      time_out();
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= 1'b1;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask

   // Read notes its expectation for the monitor
   task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= 1'b0;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      exp_rd.push_back(e);
      rd_chk <= 1'b1;
      wait_rdy();
      rd_chk <= 1'b0;
   endtask

   // Monitor of read data, transmit starts and outcomes
   always @(posedge clk_sys) begin
      if (rd_chk === 1'b1 && hready === 1'b1 && exp_rd.size() > 0) begin
         check(hrdata, exp_rd.pop_front());
         check({31'h0, hresp}, 32'h0);
      end
      if (tx_start === 1'b1) begin
         n_start <= n_start + 1;
         if (exp_tx.size() > 0) begin
            check({29'h0, tx_prio, tx_buf}, {29'h0, exp_tx.pop_front()});
         end
      end
      if ((tx_ok | tx_aborted | tx_arb_lost | tx_bus_err) === 1'b1) begin
         n_out <= n_out + 1;
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      int p;
      int q;
      int w;
      int k;
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      rx_remote = 2'h0;
      mode = 2'h0;
      delay = 4'h1;
      rd_chk = 1'b0;
      void'($urandom(32'h1f0afbc8));
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      // Reset values and an unmapped place
      for (k = 0; k < 5; k++) begin
         bus_rd(8'(k * 4), 32'h0);
      end
      bus_wr(8'h10, 32'hFFFF);
      bus_rd(8'h10, 32'h0);
      check({31'h0, irq}, 32'h0);
      $display("Test reset finished");
      // Both buffers pending, every priority level on buffer 0
      for (p = 0; p < 4; p++) begin
         q = $urandom % 4;
         delay <= 4'($urandom % 8 + 1);
         bus_wr(cbc_pkg::CBC_OFF_MASK, (p == 0) ? 32'h1 : 32'h0);
         w = (p > q) ? 0 : 1;
         exp_tx.push_back(w ? {2'(q), 1'b1} : {2'(p), 1'b0});
         exp_tx.push_back(w ? {2'(p), 1'b0} : {2'(q), 1'b1});
         k = n_out;
         bus_wr(cbc_pkg::CBC_OFF_CTRL,
            {16'h0, 8'h88 | 8'(q), 8'h88 | 8'(p)});
         wait_ev(1'b0, k + 2);
         check({31'h0, irq}, (p == 0) ? 32'h1 : 32'h0);
         check({30'h0, buf_is_tx}, 32'h3);
         bus_rd(cbc_pkg::CBC_OFF_CTRL,
            {16'h0, 8'h80 | 8'(q), 8'h80 | 8'(p)});
         bus_rd(cbc_pkg::CBC_OFF_STAT, 32'h11);
         bus_wr(cbc_pkg::CBC_OFF_STAT, 32'h11);
         bus_rd(cbc_pkg::CBC_OFF_STAT, 32'h0);
      end
      check({31'h0, irq}, 32'h0);
      $display("Test priority finished");
      // Lost arbitration, then bus error after a new request
      p = $urandom % 4;
      w = n_out;
      mode <= 2'h1;
      bus_wr(cbc_pkg::CBC_OFF_CTRL, {24'h0, 8'h88 | 8'(p)});
      wait_ev(1'b0, w + 1);
      mode <= 2'h3;
      bus_rd(cbc_pkg::CBC_OFF_CTRL, {24'h0, 8'hA8 | 8'(p)});
      mode <= 2'h0;
      wait_ev(1'b0, w + 2);
      bus_rd(cbc_pkg::CBC_OFF_CTRL, {24'h0, 8'hA0 | 8'(p)});
      mode <= 2'h2;
      bus_wr(cbc_pkg::CBC_OFF_CTRL, {24'h0, 8'h88 | 8'(p)});
      wait_ev(1'b0, w + 3);
      mode <= 2'h3;
      bus_rd(cbc_pkg::CBC_OFF_CTRL, {24'h0, 8'h98 | 8'(p)});
      mode <= 2'h0;
      wait_ev(1'b0, w + 4);
      bus_rd(cbc_pkg::CBC_OFF_CTRL, {24'h0, 8'h90 | 8'(p)});
      bus_rd(cbc_pkg::CBC_OFF_STAT, 32'hD);
      bus_wr(cbc_pkg::CBC_OFF_STAT, 32'hFF);
      $display("Test faults finished");
      // Abort of the message in service
      mode <= 2'h3;
      w = n_start;
      q = n_out;
      bus_wr(cbc_pkg::CBC_OFF_CTRL, {24'h0, 8'h88 | 8'(p)});
      wait_ev(1'b1, w + 1);
      bus_rd(cbc_pkg::CBC_OFF_STATE, {28'h0, 2'(p), 2'h1});
      bus_wr(cbc_pkg::CBC_OFF_CTRL, {24'h0, 8'h80 | 8'(p)});
      @(posedge clk_sys);
      check({31'h0, tx_abort}, 32'h1);
      wait_ev(1'b0, q + 1);
      bus_rd(cbc_pkg::CBC_OFF_CTRL, {24'h0, 8'hC0 | 8'(p)});
      bus_rd(cbc_pkg::CBC_OFF_STAT, 32'h2);
      mode <= 2'h0;
      // Abort of an idle request, then remote frames
      bus_wr(cbc_pkg::CBC_OFF_CTRL, 32'h08);
      bus_wr(cbc_pkg::CBC_OFF_CTRL, 32'h00);
      bus_rd(cbc_pkg::CBC_OFF_CTRL, 32'h40);
      bus_wr(cbc_pkg::CBC_OFF_CTRL, 32'h0404);
      @(posedge clk_sys);
      rx_remote <= 2'h3;
      @(posedge clk_sys);
      rx_remote <= 2'h0;
      bus_rd(cbc_pkg::CBC_OFF_CTRL, 32'h0C0C);
      check({30'h0, buf_is_tx}, 32'h0);
      $display("Test abort and remote finished");
      complete_run();
   end
endmodule

// file: rtl/cbc_buf_cell.sv
// Control and status bits of one message buffer
`timescale 1ns/1ps
module cbc_buf_cell (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   input wire logic ev_ok,
   input wire logic ev_abort,
   input wire logic ev_arb,
   input wire logic ev_err,
   input wire logic rx_remote,
   output logic [7:0] ctrl,
   output logic abort_req
);
   logic dir_reg;
   logic rtr_reg;
   logic [1:0] pri_reg;
   logic req_reg;
   logic abt_reg;
   logic larb_reg;
   logic err_reg;
   logic set_req;

   // (R8) remote frame sets request
   assign set_req = (wr_en & wr_data[cbc_pkg::CBC_BIT_REQ])
      | (rx_remote & rtr_reg);
   // (R7) zero over a set request aborts
   assign abort_req = wr_en & req_reg & ~wr_data[cbc_pkg::CBC_BIT_REQ]
      & ~(rx_remote & rtr_reg);

   // (R2) direction, reply enable, priority
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dir_reg <= 1'b0;
         rtr_reg <= 1'b0;
         pri_reg <= cbc_pkg::CBC_PRI_LOWEST;
      end else if (wr_en) begin
         dir_reg <= wr_data[cbc_pkg::CBC_BIT_DIR];
         rtr_reg <= wr_data[cbc_pkg::CBC_BIT_RTR];
         pri_reg <= wr_data[cbc_pkg::CBC_BIT_PRI_HI:cbc_pkg::CBC_BIT_PRI_LO];
      end
   end

   // (R6) request set by software, cleared on success
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         req_reg <= 1'b0;
      end else if (set_req) begin
         req_reg <= 1'b1;
      end else if (ev_ok | ev_abort | abort_req) begin
         req_reg <= 1'b0;
      end
   end

   // (R10) status flags cleared on new request
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         abt_reg <= 1'b0;
         larb_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         if (ev_abort) begin
            abt_reg <= 1'b1;
         end else if (set_req | ev_ok) begin
            abt_reg <= 1'b0; // (R3) success reads zero
         end
         if (ev_arb) begin
            larb_reg <= 1'b1;
         end else if (set_req) begin
            larb_reg <= 1'b0;
         end
         if (ev_err) begin
            err_reg <= 1'b1;
         end else if (set_req) begin
            err_reg <= 1'b0;
         end
      end
   end

   assign ctrl = {dir_reg, abt_reg, larb_reg, err_reg, req_reg, rtr_reg,
      pri_reg};
endmodule

// file: rtl/cbc_buffer_pair_ctrl.sv
// Control of one transmit/receive buffer pair behind an AHB-Lite slave
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Contract
// (R1) Upper byte repeats the lower byte's bits for the odd partner buffer.
// (R2) Direction bit one makes a transmit buffer, zero a receive buffer.
// (R3) Aborted flag reads one after abort, zero after successful send.
// (R4) Arbitration-lost flag set when the message loses arbitration.
// (R5) Transmit error flag set on a bus error while sending.
// (R6) Software sets send request; device clears it after success.
// (R7) Writing zero over a set send request asks for an abort.
// (R8) Remote frame with reply enabled sets send request, else unchanged.
// (R9) Priority field: 11 highest, 10, 01, 00 lowest.
// (R10) Setting send request clears aborted, lost and error flags.
// (R11) Message contents live in DMA RAM, not in these registers.
// (R12) Highest priority pending first; ties go to higher buffer number.
module cbc_buffer_pair_ctrl (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic tx_ok,
   input wire logic tx_aborted,
   input wire logic tx_arb_lost,
   input wire logic tx_bus_err,
   input wire logic [1:0] rx_remote,
   output logic tx_start,
   output logic tx_buf,
   output logic [1:0] tx_prio,
   output logic tx_abort,
   output logic [1:0] buf_is_tx,
   output logic irq
);
   localparam int NB = cbc_pkg::CBC_NBUF;

   logic wr_pend_reg;
   logic [7:0] waddr_reg;
   logic [31:0] hrdata_reg;
   logic [7:0] stat_reg;
   logic [7:0] mask_reg;
   logic [7:0] stat_set;
   logic [31:0] rd_word;
   logic acc;
   logic ctrl_wr;
   cbc_pkg::cbc_state_t state_reg;
   logic sel_reg;
   logic start_reg;
   logic abort_reg;
   logic [1:0] prio_reg;
   logic arb_valid;
   logic arb_sel;
   logic [NB-1:0] pend;
   logic [2*NB-1:0] pend_prio;
   logic [NB-1:0] abort_req;
   logic [NB-1:0] ev_ok;
   logic [NB-1:0] ev_abort;
   logic [NB-1:0] ev_arb;
   logic [NB-1:0] ev_err;
   logic [15:0] ctrl_word;
   logic busy;

   // ****************************************
   // AHB-Lite slave
   // ****************************************

   // Address phase accepted
   assign acc = hsel & htrans[1] & hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   assign ctrl_wr = wr_pend_reg & (waddr_reg == cbc_pkg::CBC_OFF_CTRL);

   // Capture write address for the data phase
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_pend_reg <= 1'b0;
         waddr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= acc & hwrite & (hsize == 3'h2);
         waddr_reg <= haddr[7:0];
      end
   end

   // Read mux, unmapped reads zero
   // (R11) only control and status here, message words stay in DMA RAM
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (haddr[7:0])
         cbc_pkg::CBC_OFF_CTRL: rd_word = {16'h0000, ctrl_word};
         cbc_pkg::CBC_OFF_STAT: rd_word = {24'h00_0000, stat_reg};
         cbc_pkg::CBC_OFF_MASK: rd_word = {24'h00_0000, mask_reg};
         cbc_pkg::CBC_OFF_STATE: rd_word = {28'h000_0000, prio_reg,
            sel_reg, busy};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // Read data registered into the data phase
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (acc & ~hwrite) begin
         hrdata_reg <= rd_word;
      end
   end

   // ****************************************
   // Buffer cells
   // ****************************************

   // (R1) one cell per buffer, odd partner in upper byte
   genvar g;
   generate
      for (g = 0; g < NB; g++) begin : g_buf
         cbc_buf_cell u_cell (
            .clk_sys(clk_sys),
            .rst(rst),
            .wr_en(ctrl_wr),
            .wr_data(hwdata[8*g +: 8]),
            .ev_ok(ev_ok[g]),
            .ev_abort(ev_abort[g]),
            .ev_arb(ev_arb[g]),
            .ev_err(ev_err[g]),
            .rx_remote(rx_remote[g]),
            .ctrl(ctrl_word[8*g +: 8]),
            .abort_req(abort_req[g])
         );
         // (R2) only transmit buffers compete
         assign pend[g] = ctrl_word[8*g + cbc_pkg::CBC_BIT_REQ]
            & ctrl_word[8*g + cbc_pkg::CBC_BIT_DIR];
         assign buf_is_tx[g] = ctrl_word[8*g + cbc_pkg::CBC_BIT_DIR];
         // (R9) two-bit priority per buffer
         assign pend_prio[2*g +: 2] = ctrl_word[8*g +: 2];
         // (R3) abort done by engine or at once if not on the bus
         assign ev_abort[g] = (abort_req[g] & ~(busy & (sel_reg == g)))
            | (busy & (sel_reg == g) & (tx_aborted
            | (abort_reg & (tx_arb_lost | tx_bus_err))));
         // (R6) success ends the request
         assign ev_ok[g] = busy & (sel_reg == g) & tx_ok;
         // (R4) lost arbitration
         assign ev_arb[g] = busy & (sel_reg == g) & tx_arb_lost;
         // (R5) bus error while sending
         assign ev_err[g] = busy & (sel_reg == g) & tx_bus_err;
         assign stat_set[4*g + cbc_pkg::CBC_EV_OK] = ev_ok[g];
         assign stat_set[4*g + cbc_pkg::CBC_EV_ABT] = ev_abort[g];
         assign stat_set[4*g + cbc_pkg::CBC_EV_ARB] = ev_arb[g];
         assign stat_set[4*g + cbc_pkg::CBC_EV_ERR] = ev_err[g];
      end
   endgenerate

   // ****************************************
   // Transmit sequencer
   // ****************************************

   // (R12) priority pick among pending buffers
   cbc_tx_arbiter #(
      .NBUF(NB),
      .SEL_W(1)
   ) u_arb (
      .pend(pend),
      .prio(pend_prio),
      .valid(arb_valid),
      .sel(arb_sel)
   );

   assign busy = (state_reg == cbc_pkg::CBC_BUSY);
   assign tx_start = start_reg;
   assign tx_buf = sel_reg;
   assign tx_prio = prio_reg;
   assign tx_abort = abort_reg;

   // Start one attempt, wait for its outcome
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg <= cbc_pkg::CBC_IDLE;
         sel_reg <= 1'b0;
         start_reg <= 1'b0;
         prio_reg <= cbc_pkg::CBC_PRI_LOWEST;
      end else begin
         start_reg <= 1'b0;
         unique case (state_reg)
            cbc_pkg::CBC_IDLE: begin
               if (arb_valid) begin
                  state_reg <= cbc_pkg::CBC_BUSY;
                  sel_reg <= arb_sel;
                  prio_reg <= pend_prio[2*arb_sel +: 2];
                  start_reg <= 1'b1;
               end
            end
            cbc_pkg::CBC_BUSY: begin
               if (tx_ok | tx_aborted | tx_arb_lost | tx_bus_err) begin
                  state_reg <= cbc_pkg::CBC_IDLE;
               end
            end
         endcase
      end
   end

   // (R7) abort request to engine for active buffer
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         abort_reg <= 1'b0;
      end else if (~busy | tx_ok | tx_aborted | tx_arb_lost | tx_bus_err) begin
         abort_reg <= 1'b0;
      end else if (abort_req[sel_reg]) begin
         abort_reg <= 1'b1;
      end
   end

   // ****************************************
   // Interrupts
   // ****************************************

   // Sticky status, write one clears, set wins
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stat_reg <= 8'h00;
      end else if (wr_pend_reg & (waddr_reg == cbc_pkg::CBC_OFF_STAT)) begin
         stat_reg <= (stat_reg & ~hwdata[7:0]) | stat_set;
      end else begin
         stat_reg <= stat_reg | stat_set;
      end
   end

   // Interrupt mask
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mask_reg <= cbc_pkg::CBC_MASK_RST;
      end else if (wr_pend_reg & (waddr_reg == cbc_pkg::CBC_OFF_MASK)) begin
         mask_reg <= hwdata[7:0];
      end
   end

   assign irq = |(stat_reg & mask_reg);

   // ****************************************
   // Assertions
   // ****************************************

   AST_PAIR_COPY: assert property (@(posedge clk_sys) disable iff (rst) // (R1)
      ctrl_wr & ~rx_remote[1] |=> ctrl_word[15] == $past(hwdata[15])
      && ctrl_word[10] == $past(hwdata[10]))
      else $error("upper byte not written for partner buffer");

   AST_DIR_PICK: assert property (@(posedge clk_sys) disable iff (rst) // (R2)
      tx_start |-> ctrl_word[8*tx_buf + cbc_pkg::CBC_BIT_DIR])
      else $error("receive buffer started for transmit");

   AST_ABT_FLAG: assert property (@(posedge clk_sys) disable iff (rst) // (R3)
      busy & tx_aborted |=> ctrl_word[8*$past(sel_reg) + 6]
      && !ctrl_word[8*$past(sel_reg) + 3])
      else $error("aborted flag not set after abort");

   AST_ARB_FLAG: assert property (@(posedge clk_sys) disable iff (rst) // (R4)
      busy & tx_arb_lost |=> ctrl_word[8*$past(sel_reg) + 5])
      else $error("lost arbitration flag not set");

   AST_ERR_FLAG: assert property (@(posedge clk_sys) disable iff (rst) // (R5)
      busy & tx_bus_err |=> ctrl_word[8*$past(sel_reg) + 4] && !busy)
      else $error("bus error flag not set");

   AST_OK_CLEAR: assert property (@(posedge clk_sys) disable iff (rst) // (R6)
      busy & tx_ok & ~ctrl_wr & ~(|rx_remote)
      |=> !ctrl_word[8*$past(sel_reg) + 3]
      ##1 !(tx_start & (tx_buf == $past(sel_reg, 2))))
      else $error("request not cleared after success");

   AST_ABORT_REQ: assert property (@(posedge clk_sys) disable iff (rst) // (R7)
      busy & abort_req[sel_reg] & ~(tx_ok | tx_aborted | tx_arb_lost
      | tx_bus_err) |=> tx_abort)
      else $error("abort not passed to engine");

   AST_RTR_SET: assert property (@(posedge clk_sys) disable iff (rst) // (R8)
      rx_remote[0] & ctrl_word[2] & ~tx_ok & ~tx_aborted |=> ctrl_word[3])
      else $error("remote frame did not set request");

   AST_FLAG_CLR: assert property (@(posedge clk_sys) disable iff (rst) // (R10)
      $rose(ctrl_word[3]) |-> ctrl_word[6:4] == 3'h0)
      else $error("flags not cleared by new request");

   AST_PRIO_PICK: assert property (@(posedge clk_sys) disable iff (rst) // (R12)
      !busy & pend[0] & pend[1] |=> tx_start
      && tx_prio >= $past(pend_prio[1:0]) && tx_prio >= $past(pend_prio[3:2]))
      else $error("lower priority buffer started first");

   COV_SEND_OK: cover property (@(posedge clk_sys) disable iff (rst)
      tx_start ##[1:20] (busy & tx_ok));
   COV_ABORT: cover property (@(posedge clk_sys) disable iff (rst)
      tx_abort ##[1:20] tx_aborted);
   COV_REMOTE: cover property (@(posedge clk_sys) disable iff (rst)
      rx_remote[1] & ctrl_word[10] ##[1:5] tx_start);
   COV_IRQ: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));
endmodule

// file: rtl/cbc_pkg.sv
// Constants and types for the CAN buffer pair control block
package cbc_pkg;
   // ****************************************
   // Sizes
   // ****************************************
   localparam int CBC_NBUF = 2;
   localparam int CBC_BYTE_W = 8;
   localparam int CBC_PRI_W = 2;
   localparam int CBC_EV_W = 4;

   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] CBC_OFF_CTRL = 8'h00;
   localparam logic [7:0] CBC_OFF_STAT = 8'h04;
   localparam logic [7:0] CBC_OFF_MASK = 8'h08;
   localparam logic [7:0] CBC_OFF_STATE = 8'h0C;

   // ****************************************
   // Control byte fields, one byte per buffer
   // ****************************************
   localparam int CBC_BIT_DIR = 7;
   localparam int CBC_BIT_ABT = 6;
   localparam int CBC_BIT_LARB = 5;
   localparam int CBC_BIT_ERR = 4;
   localparam int CBC_BIT_REQ = 3;
   localparam int CBC_BIT_RTR = 2;
   localparam int CBC_BIT_PRI_HI = 1;
   localparam int CBC_BIT_PRI_LO = 0;
   localparam logic [7:0] CBC_CTRL_RST = 8'h00;

   // Priority encodings
   localparam logic [1:0] CBC_PRI_HIGHEST = 2'h3;
   localparam logic [1:0] CBC_PRI_HIGH_MID = 2'h2;
   localparam logic [1:0] CBC_PRI_LOW_MID = 2'h1;
   localparam logic [1:0] CBC_PRI_LOWEST = 2'h0;

   // ****************************************
   // Interrupt status layout: bit = buffer * 4 + event
   // ****************************************
   localparam int CBC_EV_OK = 0;
   localparam int CBC_EV_ABT = 1;
   localparam int CBC_EV_ARB = 2;
   localparam int CBC_EV_ERR = 3;
   localparam logic [7:0] CBC_MASK_RST = 8'h00;

   // Transmit sequencer states
   typedef enum logic [0:0] {
      CBC_IDLE = 1'b0,
      CBC_BUSY = 1'b1
   } cbc_state_t;
endpackage

// file: rtl/cbc_tx_arbiter.sv
// Picks the pending transmit buffer of highest priority
`timescale 1ns/1ps
module cbc_tx_arbiter #(
   parameter int NBUF = 2,
   parameter int SEL_W = 1
) (
   input wire logic [NBUF-1:0] pend,
   input wire logic [2*NBUF-1:0] prio,
   output logic valid,
   output logic [SEL_W-1:0] sel
);
   logic [1:0] best;

   // (R12) higher field wins, tie to higher buffer
   always_comb begin
      valid = 1'b0;
      sel = '0;
      best = 2'h0;
      for (int i = 0; i < NBUF; i++) begin
         if (pend[i] && (!valid || prio[2*i +: 2] >= best)) begin
            valid = 1'b1;
            sel = SEL_W'(i);
            best = prio[2*i +: 2];
         end
      end
   end
endmodule
